// file: hw/security_peripheral_control_bank.sv
// security and peripheral control bank: config bytes, indexed diskette control, gating outputs
// Behaviour
// - diskette disable bit one blocks all diskette access; default zero allows it
// - while lock bit is one, writes cannot change the diskette disable bit
// - diskette write-enable bit zero suppresses diskette writes; default one
// - two-bit field places parallel port: primary, secondary, tertiary, or disabled
// - fixed disk controller enabled by its bit one, disabled by zero
// - serial interface enabled by its bit one, disabled by zero
// - lowest bit of first peripheral byte enables diskette controller; others reserved
// - second peripheral byte also reachable through a fixed i/o port
// - keyboard-lock enable bit, default zero
// - screen blank bit enables blanking and implies keyboard lock
// - boot control bit inverted: zero permits diskette boot, one prevents
// - admin password bit reports presence
// - lock override bit enables network server override
`timescale 1ns/1ns
`default_nettype none
module security_peripheral_control_bank (
    input  wire logic        clk,
    input  wire logic        reset_n,
    // configuration memory port
    input  wire logic [7:0]  cfg_addr,
    input  wire logic        cfg_wr,
    input  wire logic        cfg_rd,
    input  wire logic [7:0]  cfg_wdata,
    output logic      [7:0]  cfg_rdata,
    // system i/o port (index byte selects register behind the diskette port)
    input  wire logic [15:0] io_addr,
    input  wire logic [7:0]  io_index,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    input  wire logic [7:0]  io_wdata,
    output logic      [7:0]  io_rdata,
    output logic             io_hit,
    // diskette requests to gate
    input  wire logic        dsk_req,
    input  wire logic        dsk_req_write,
    output logic             dsk_grant,
    output logic             dsk_write_grant,
    // peripheral gating
    output logic             diskette_ctrl_en,
    output logic             fixed_disk_en,
    output logic             serial_en,
    output logic             parallel_en,
    output logic      [1:0]  parallel_place,
    // security settings
    output logic             password_set,
    output logic             lock_override,
    output logic             keylock_en,
    output logic             diskette_boot_ok,
    output logic             admin_pw_present,
    output logic             blank_en
);
    import secbank_pkg::*;

    logic [7:0] sec_q;
    logic [7:0] pa_q;
    logic [7:0] pb_q;
    logic [7:0] dc_q;
    logic       wr_sec;
    logic       wr_pa;
    logic       wr_pb;
    logic       wr_pb_cfg;
    logic       wr_pb_io;
    logic       wr_dc;
    logic       rd_dc;
    logic [7:0] dc_mask;
    logic [7:0] next_cfg_rdata;
    logic [7:0] next_io_rdata;

    function automatic logic io_is_dc(input logic [15:0] a, input logic [7:0] idx);
        return a == IO_DISKETTE_CTRL && idx == DISKETTE_CTRL_INDEX;
    endfunction

    assign wr_sec = cfg_wr && cfg_addr == CFG_SECURITY_STATUS;
    assign wr_pa  = cfg_wr && cfg_addr == CFG_PERIPH_A;
    // same storage from both paths; the i/o port wins a same-cycle collision
    assign wr_pb_cfg = cfg_wr && cfg_addr == CFG_PERIPH_B;
    assign wr_pb_io  = io_wr && io_addr == IO_PERIPH_B;
    assign wr_pb  = wr_pb_cfg || wr_pb_io;
    assign wr_dc  = io_wr && io_is_dc(io_addr, io_index);
    assign rd_dc  = io_rd && io_is_dc(io_addr, io_index);
    // lock bit freezes the disable bit, lock and write-enable stay writable
    assign dc_mask = dc_q[DC_LOCK_BIT] ? ~(8'h01 << DC_DISABLE_BIT) : 8'hFF;

    byte_reg #(.RESET_VALUE(SECURITY_RESET)) u_sec (
        .clk     (clk),
        .reset_n (reset_n),
        .wr      (wr_sec),
        .wmask   (8'hFF),
        .wdata   (cfg_wdata),
        .q       (sec_q)
    );
    byte_reg #(.RESET_VALUE(PERIPH_A_RESET)) u_pa (
        .clk     (clk),
        .reset_n (reset_n),
        .wr      (wr_pa),
        .wmask   (8'hFF),
        .wdata   (cfg_wdata),
        .q       (pa_q)
    );
    byte_reg #(.RESET_VALUE(PERIPH_B_RESET)) u_pb (
        .clk     (clk),
        .reset_n (reset_n),
        .wr      (wr_pb),
        .wmask   (8'hFF),
        .wdata   (wr_pb_io ? io_wdata : cfg_wdata),
        .q       (pb_q)
    );
    byte_reg #(.RESET_VALUE(DISKETTE_CTRL_RESET)) u_dc (
        .clk     (clk),
        .reset_n (reset_n),
        .wr      (wr_dc),
        .wmask   (dc_mask),
        .wdata   (io_wdata),
        .q       (dc_q)
    );

    always_comb begin
        next_cfg_rdata = cfg_rdata;
        if (cfg_rd) begin
            unique case (cfg_addr)
                CFG_SECURITY_STATUS: next_cfg_rdata = sec_q;
                CFG_PERIPH_A:        next_cfg_rdata = pa_q;
                CFG_PERIPH_B:        next_cfg_rdata = pb_q;
                default:             next_cfg_rdata = 8'h00;
            endcase
        end
        next_io_rdata = io_rdata;
        if (io_rd) begin
            if (io_addr == IO_PERIPH_B) begin
                next_io_rdata = pb_q;
            end else if (io_is_dc(io_addr, io_index)) begin
                next_io_rdata = dc_q;
            end else begin
                next_io_rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_rdata <= 8'h00;
            io_rdata  <= 8'h00;
        end else begin
            cfg_rdata <= next_cfg_rdata;
            io_rdata  <= next_io_rdata;
        end
    end

    assign io_hit = io_addr == IO_PERIPH_B || io_is_dc(io_addr, io_index);

    // access gating is combinational so a request never sees a stale grant
    assign dsk_grant        = dsk_req && !dc_q[DC_DISABLE_BIT] && pa_q[PA_DISKETTE_EN];
    assign dsk_write_grant  = dsk_grant && dsk_req_write && dc_q[DC_WRITE_EN_BIT];
    assign diskette_ctrl_en = pa_q[PA_DISKETTE_EN];
    assign fixed_disk_en    = pb_q[PB_FIXED_DISK_EN];
    assign serial_en        = pb_q[PB_SERIAL_EN];
    assign parallel_place   = pb_q[PB_PARALLEL_LO +: 2];
    assign parallel_en      = pb_q[PB_PARALLEL_LO +: 2] != PAR_DISABLED;
    assign password_set     = sec_q[SS_PASSWORD_SET];
    assign lock_override    = sec_q[SS_LOCK_OVERRIDE];
    assign blank_en         = sec_q[SS_BLANK_EN];
    assign keylock_en       = sec_q[SS_KEYLOCK_EN] || sec_q[SS_BLANK_EN];
    assign diskette_boot_ok = !sec_q[SS_BOOT_DISABLE];
    assign admin_pw_present = sec_q[SS_ADMIN_PW];

    chk_disable_blocks: assert property (@(posedge clk) disable iff (!reset_n)
        dc_q[DC_DISABLE_BIT]
        |-> !dsk_grant)
        else $error("diskette access granted while disabled");

    chk_grant_allowed: assert property (@(posedge clk) disable iff (!reset_n)
        (dsk_req && !dc_q[DC_DISABLE_BIT] && pa_q[PA_DISKETTE_EN])
        |-> dsk_grant)
        else $error("diskette access refused while allowed");

    chk_grant_needs_req: assert property (@(posedge clk) disable iff (!reset_n)
        !dsk_req
        |-> !dsk_grant)
        else $error("diskette grant without request");

    chk_lock_holds_bit: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_dc && dc_q[DC_LOCK_BIT])
        |=> $stable(dc_q[DC_DISABLE_BIT]))
        else $error("locked disable bit changed");

    chk_locked_others: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_dc && dc_q[DC_LOCK_BIT])
        |=> dc_q[DC_WRITE_EN_BIT] == $past(io_wdata[DC_WRITE_EN_BIT]))
        else $error("write enable not written while locked");

    chk_unlocked_write: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_dc && !dc_q[DC_LOCK_BIT])
        |=> dc_q == $past(io_wdata))
        else $error("diskette control write lost");

    chk_dc_idle: assert property (@(posedge clk) disable iff (!reset_n)
        !wr_dc
        |=> $stable(dc_q))
        else $error("diskette control changed without write");

    chk_dc_read: assert property (@(posedge clk) disable iff (!reset_n)
        rd_dc
        |=> io_rdata == $past(dc_q))
        else $error("diskette control read mismatch");

    chk_write_inhibit: assert property (@(posedge clk) disable iff (!reset_n)
        !dc_q[DC_WRITE_EN_BIT]
        |-> !dsk_write_grant)
        else $error("diskette write passed while inhibited");

    chk_write_allowed: assert property (@(posedge clk) disable iff (!reset_n)
        (dsk_grant && dsk_req_write && dc_q[DC_WRITE_EN_BIT])
        |-> dsk_write_grant)
        else $error("diskette write refused while allowed");

    chk_write_needs_grant: assert property (@(posedge clk) disable iff (!reset_n)
        !dsk_grant
        |-> !dsk_write_grant)
        else $error("diskette write without access grant");

    chk_parallel_off: assert property (@(posedge clk) disable iff (!reset_n)
        (pb_q[PB_PARALLEL_LO +: 2] == PAR_DISABLED)
        |-> !parallel_en)
        else $error("parallel enabled while disabled");

    chk_parallel_place: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_pb_cfg && !wr_pb_io)
        |=> parallel_place == $past(cfg_wdata[PB_PARALLEL_LO +: 2]))
        else $error("parallel placement not written");

    chk_fixed_disk: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_pb_cfg && !wr_pb_io)
        |=> fixed_disk_en == $past(cfg_wdata[PB_FIXED_DISK_EN]))
        else $error("fixed disk enable not written");

    chk_serial_gate: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_pb_cfg && !wr_pb_io)
        |=> serial_en == $past(cfg_wdata[PB_SERIAL_EN]))
        else $error("serial enable not written");

    chk_diskette_ctrl: assert property (@(posedge clk) disable iff (!reset_n)
        !diskette_ctrl_en
        |-> !dsk_grant)
        else $error("disabled controller granted access");

    chk_pa_write: assert property (@(posedge clk) disable iff (!reset_n)
        wr_pa
        |=> pa_q == $past(cfg_wdata))
        else $error("first peripheral byte not written");

    chk_pa_idle: assert property (@(posedge clk) disable iff (!reset_n)
        !wr_pa
        |=> $stable(pa_q))
        else $error("first peripheral byte changed without write");

    chk_io_mirror: assert property (@(posedge clk) disable iff (!reset_n)
        (io_rd && io_addr == IO_PERIPH_B)
        |=> io_rdata == $past(pb_q))
        else $error("i/o mirror mismatch");

    chk_io_write_wins: assert property (@(posedge clk) disable iff (!reset_n)
        wr_pb_io
        |=> pb_q == $past(io_wdata))
        else $error("i/o write to second peripheral byte lost");

    chk_cfg_mirror: assert property (@(posedge clk) disable iff (!reset_n)
        (cfg_rd && cfg_addr == CFG_PERIPH_B)
        |=> cfg_rdata == $past(pb_q))
        else $error("config read of second peripheral byte mismatch");

    chk_pb_idle: assert property (@(posedge clk) disable iff (!reset_n)
        !wr_pb
        |=> $stable(pb_q))
        else $error("second peripheral byte changed without write");

    chk_password_bit: assert property (@(posedge clk) disable iff (!reset_n)
        wr_sec
        |=> password_set == $past(cfg_wdata[SS_PASSWORD_SET]))
        else $error("password state not written");

    chk_keylock_write: assert property (@(posedge clk) disable iff (!reset_n)
        wr_sec
        |=> keylock_en == ($past(cfg_wdata[SS_KEYLOCK_EN]) || $past(cfg_wdata[SS_BLANK_EN])))
        else $error("keyboard lock enable wrong");

    chk_sec_idle: assert property (@(posedge clk) disable iff (!reset_n)
        !wr_sec
        |=> $stable(sec_q))
        else $error("security byte changed without write");

    chk_blank_keylock: assert property (@(posedge clk) disable iff (!reset_n)
        blank_en
        |-> keylock_en)
        else $error("blanking without keyboard lock");

    chk_blank_write: assert property (@(posedge clk) disable iff (!reset_n)
        wr_sec
        |=> blank_en == $past(cfg_wdata[SS_BLANK_EN]))
        else $error("blank enable not written");

    chk_boot_polarity: assert property (@(posedge clk) disable iff (!reset_n)
        wr_sec
        |=> diskette_boot_ok == !$past(cfg_wdata[SS_BOOT_DISABLE]))
        else $error("boot polarity wrong");

    chk_admin_write: assert property (@(posedge clk) disable iff (!reset_n)
        wr_sec
        |=> admin_pw_present == $past(cfg_wdata[SS_ADMIN_PW]))
        else $error("administrator password bit not written");

    chk_override_write: assert property (@(posedge clk) disable iff (!reset_n)
        wr_sec
        |=> lock_override == $past(cfg_wdata[SS_LOCK_OVERRIDE]))
        else $error("lock override bit not written");

    cov_locked_disable: cover property (@(posedge clk) disable iff (!reset_n)
        dc_q[DC_LOCK_BIT] && dc_q[DC_DISABLE_BIT]);
    cov_locked_write:  cover property (@(posedge clk) disable iff (!reset_n) wr_dc && dc_q[DC_LOCK_BIT]);
    cov_write_blocked: cover property (@(posedge clk) disable iff (!reset_n)
        dsk_req && dsk_req_write && dsk_grant && !dsk_write_grant);
    cov_io_mirror:     cover property (@(posedge clk) disable iff (!reset_n) io_wr && io_addr == IO_PERIPH_B);
    cov_par_off:       cover property (@(posedge clk) disable iff (!reset_n) !parallel_en);
endmodule // security_peripheral_control_bank
`default_nettype wire

// file: hw/secbank_pkg.sv
// constants for the security and peripheral control bank
package secbank_pkg;
    // configuration memory locations
    localparam logic [7:0]  CFG_SECURITY_STATUS = 8'h13;
    localparam logic [7:0]  CFG_PERIPH_A        = 8'h26;
    localparam logic [7:0]  CFG_PERIPH_B        = 8'h29;
    // direct i/o ports
    localparam logic [15:0] IO_PERIPH_B         = 16'h0C65;
    localparam logic [15:0] IO_DISKETTE_CTRL    = 16'h2065;
    localparam logic [7:0]  DISKETTE_CTRL_INDEX = 8'h99;
    // diskette control fields
    localparam int          DC_DISABLE_BIT      = 1;
    localparam int          DC_LOCK_BIT         = 2;
    localparam int          DC_WRITE_EN_BIT     = 3;
    // security status fields
    localparam int          SS_PASSWORD_SET     = 0;
    localparam int          SS_LOCK_OVERRIDE    = 1;
    localparam int          SS_KEYLOCK_EN       = 2;
    localparam int          SS_BOOT_DISABLE     = 3;
    localparam int          SS_ADMIN_PW         = 5;
    localparam int          SS_BLANK_EN         = 6;
    // peripheral fields
    localparam int          PA_DISKETTE_EN      = 0;
    localparam int          PB_SERIAL_EN        = 1;
    localparam int          PB_FIXED_DISK_EN    = 4;
    localparam int          PB_PARALLEL_LO      = 5;
    // reset values
    localparam logic [7:0]  DISKETTE_CTRL_RESET = 8'h08;
    localparam logic [7:0]  SECURITY_RESET      = 8'h00;
    localparam logic [7:0]  PERIPH_A_RESET      = 8'h01;
    localparam logic [7:0]  PERIPH_B_RESET      = 8'h12;
    // parallel placement codes
    localparam logic [1:0]  PAR_PRIMARY         = 2'h0;
    localparam logic [1:0]  PAR_SECONDARY       = 2'h1;
    localparam logic [1:0]  PAR_TERTIARY        = 2'h2;
    localparam logic [1:0]  PAR_DISABLED        = 2'h3;
endpackage : secbank_pkg

// file: hw/byte_reg.sv
// one byte register with per-bit write mask
`timescale 1ns/1ns
`default_nettype none
module byte_reg #(
    parameter logic [7:0] RESET_VALUE = 8'h00
) (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       wr,
    input  wire logic [7:0] wmask,
    input  wire logic [7:0] wdata,
    output logic      [7:0] q
);
    logic [7:0] next_q;

    always_comb begin
        next_q = q;
        if (wr) begin
            next_q = (q & ~wmask) | (wdata & wmask);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= RESET_VALUE;
        end else begin
            q <= next_q;
        end
    end
endmodule // byte_reg
`default_nettype wire

// file: tb/tb_security_peripheral_control_bank.sv
// self-checking bench for the security and peripheral control bank
`timescale 1ns/1ns
`default_nettype none
module tb_security_peripheral_control_bank;
    import secbank_pkg::*;
    logic        clk, reset_n, cfg_wr, cfg_rd, io_wr, io_rd, dsk_req, dsk_req_write, io_hit;
    logic [7:0]  cfg_addr, cfg_wdata, cfg_rdata, io_index, io_wdata, io_rdata, d, pa, pb, ss, dc;
    logic [15:0] io_addr;
    logic        dsk_grant, dsk_write_grant, diskette_ctrl_en, fixed_disk_en, serial_en, parallel_en;
    logic [1:0]  parallel_place;
    logic        password_set, lock_override, keylock_en, diskette_boot_ok, admin_pw_present, blank_en;
    logic        pend_c, pend_i;
    logic [7:0]  exp_q[$];
    logic [7:0]  dw[5] = '{8'h0A, 8'h0E, 8'h0C, 8'h00, 8'h08};
    logic [7:0]  de[5] = '{8'h0A, 8'h0E, 8'h0E, 8'h02, 8'h08};
    int          errors, n_compared, seed;

    security_peripheral_control_bank dut (.clk, .reset_n, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_wdata, .cfg_rdata,
        .io_addr, .io_index, .io_wr, .io_rd, .io_wdata, .io_rdata, .io_hit, .dsk_req, .dsk_req_write,
        .dsk_grant, .dsk_write_grant, .diskette_ctrl_en, .fixed_disk_en, .serial_en, .parallel_en,
        .parallel_place, .password_set, .lock_override, .keylock_en, .diskette_boot_ok, .admin_pw_present,
        .blank_en);

    task automatic check_byte(string what, logic [7:0] e, logic [7:0] s);
        n_compared++;
        if (s !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic check_bit(string what, logic e, logic s);
        check_byte(what, {7'h00, e}, {7'h00, s});
    endtask
    task automatic tally_and_finish();
        if (errors == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // reads queue their expected byte; the monitor below pairs it with the answer
    task automatic cfg_acc(logic w, logic [7:0] a, logic [7:0] v);
        cfg_addr = a;
        cfg_wdata = v;
        cfg_wr = w;
        cfg_rd = !w;
        if (!w) exp_q.push_back(v);
        @(posedge clk); #1;
        cfg_wr = 0;
        cfg_rd = 0;
        @(posedge clk); #1;
    endtask
    task automatic io_acc(logic w, logic [15:0] a, logic [7:0] idx, logic [7:0] v);
        io_addr = a;
        io_index = idx;
        io_wdata = v;
        io_wr = w;
        io_rd = !w;
        if (!w) exp_q.push_back(v);
        #1 check_bit("io_hit", a == IO_PERIPH_B || (a == IO_DISKETTE_CTRL && idx == DISKETTE_CTRL_INDEX), io_hit);
        @(posedge clk); #1;
        io_wr = 0;
        io_rd = 0;
        @(posedge clk); #1;
    endtask
    task automatic check_outs();
        d = $random(seed);
        dsk_req = d[0];
        dsk_req_write = d[1];
        #1 check_bit("dsk_grant", dsk_req & !dc[DC_DISABLE_BIT] & pa[0], dsk_grant);
        check_bit("dsk_write_grant", dsk_grant & dsk_req_write & dc[DC_WRITE_EN_BIT], dsk_write_grant);
        check_bit("diskette_ctrl_en", pa[PA_DISKETTE_EN], diskette_ctrl_en);
        check_bit("fixed_disk_en", pb[PB_FIXED_DISK_EN], fixed_disk_en);
        check_bit("serial_en", pb[PB_SERIAL_EN], serial_en);
        check_bit("parallel_en", pb[6:5] != PAR_DISABLED, parallel_en);
        check_byte("parallel_place", {6'h00, pb[6:5]}, {6'h00, parallel_place});
        check_bit("password_set", ss[SS_PASSWORD_SET], password_set);
        check_bit("lock_override", ss[SS_LOCK_OVERRIDE], lock_override);
        check_bit("keylock_en", ss[SS_KEYLOCK_EN] | ss[SS_BLANK_EN], keylock_en);
        check_bit("diskette_boot_ok", !ss[SS_BOOT_DISABLE], diskette_boot_ok);
        check_bit("admin_pw_present", ss[SS_ADMIN_PW], admin_pw_present);
        check_bit("blank_en", ss[SS_BLANK_EN], blank_en);
    endtask

    always @(posedge clk) begin
        pend_c <= cfg_rd;
        pend_i <= io_rd;
    end
    always @(negedge clk) begin
        if (pend_c) check_byte("cfg_rdata", exp_q.pop_front(), cfg_rdata);
        if (pend_i) check_byte("io_rdata", exp_q.pop_front(), io_rdata);
    end

    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    initial begin
        #(40 * 3000);
        errors++;
        tally_and_finish();
    end
    initial begin
        {reset_n, cfg_wr, cfg_rd, io_wr, io_rd, dsk_req, dsk_req_write, pend_c, pend_i} = '0;
        {cfg_addr, cfg_wdata, io_index, io_wdata, io_addr} = '0;
        {errors, n_compared, seed} = {32'd0, 32'd0, 32'd83581};
        {ss, pa, pb, dc} = {SECURITY_RESET, PERIPH_A_RESET, PERIPH_B_RESET, DISKETTE_CTRL_RESET};
        repeat (2) @(posedge clk);
        #1 reset_n = 1;
        check_outs();
        cfg_acc(0, CFG_SECURITY_STATUS, ss);
        cfg_acc(0, CFG_PERIPH_A, pa);
        cfg_acc(0, CFG_PERIPH_B, pb);
        io_acc(0, IO_DISKETTE_CTRL, DISKETTE_CTRL_INDEX, dc);
        cfg_acc(0, 8'h3F, 8'h00);
        // every placement code, with random neighbours in the other bytes
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            pb = {d[7], i[1:0], d[4:0]};
            {pa, ss} = 16'($random(seed));
            cfg_acc(1, CFG_PERIPH_B, pb);
            cfg_acc(1, CFG_PERIPH_A, pa);
            cfg_acc(1, CFG_SECURITY_STATUS, ss);
            check_outs();
            io_acc(0, IO_PERIPH_B, 8'h00, pb);
            cfg_acc(0, CFG_SECURITY_STATUS, ss);
        end
        pb = $random(seed);
        io_acc(1, IO_PERIPH_B, 8'h00, pb);
        cfg_acc(0, CFG_PERIPH_B, pb);
        pa = {pa[7:1], 1'b1};
        cfg_acc(1, CFG_PERIPH_A, pa);
        // the third and fourth writes land while locked; the fourth clears the lock in the same write
        for (int i = 0; i < 5; i++) begin
            io_acc(1, IO_DISKETTE_CTRL, DISKETTE_CTRL_INDEX, dw[i]);
            dc = de[i];
            check_outs();
            io_acc(0, IO_DISKETTE_CTRL, DISKETTE_CTRL_INDEX, dc);
        end
        io_acc(1, IO_DISKETTE_CTRL, 8'h98, 8'hFF);
        io_acc(0, IO_DISKETTE_CTRL, DISKETTE_CTRL_INDEX, dc);
        @(posedge clk);
        tally_and_finish();
    end
endmodule // tb_security_peripheral_control_bank
`default_nettype wire
